// ---- hw/lsf_top.sv ----
// top: link status, direction, network and static forwarding registers
// assumes: switch fabric presents one header pulse per packet per link
//
// Functional notes
// - each link status word shows the source target type in bits 25:24.
// - bits 23:16 show the destination link number while the link is in use.
// - bits 11:8 are a writable per-link direction, reset to zero.
// - bits 5:4 are a writable per-link network number, reset to zero.
// - bit 2 flags a junk packet, which is dropped and never forwarded.
// - bit 1 is high while the destination side of the link is busy.
// - bit 0 is high while the source side of the link is busy.
// - link words sit at consecutive registers from 0x20 for links 0 to 7.
// - static enable bit 31 forwards all non-junk link traffic to one channel end, unrouted.
// - static bit 8 picks the destination processor on this node.
// - static bits 4:0 pick the destination channel end on this node.
// - static words 0xa0 to 0xa7 serve links C, D, A, B, G, H, E, F in order.
// - routed packets take the direction of their highest mismatching node id bit, or the link direction when the node ids match.
module lsf_top #(
  parameter int NLINK = lsf_pkg::NLINK
) (
  input wire logic i_ref_clk,
  input wire logic i_rst,
  input wire logic [7:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [31:0] o_rdata,
  input wire logic [NLINK-1:0] i_hdr_valid,
  input wire logic [NLINK-1:0] i_hdr_junk,
  input wire logic [NLINK*8-1:0] i_hdr_node,
  input wire logic [NLINK*8-1:0] i_hdr_dst_link,
  input wire logic [NLINK-1:0] i_pkt_end,
  input wire logic [NLINK-1:0] i_dst_busy,
  input wire logic [NLINK*2-1:0] i_src_type,
  output logic [NLINK-1:0] o_fwd_valid,
  output logic [NLINK-1:0] o_fwd_drop,
  output logic [NLINK-1:0] o_fwd_static,
  output logic [NLINK-1:0] o_fwd_proc,
  output logic [NLINK*5-1:0] o_fwd_chanend,
  output logic [NLINK*4-1:0] o_fwd_dir,
  output logic [NLINK*2-1:0] o_fwd_net
);
  if (NLINK != 8) begin : g_bad_nlink
    $error("lsf_top serves exactly eight links");
  end

  // ------------------------------------------------------------
  // configuration storage
  // ------------------------------------------------------------
  logic [3:0] dir_ff [NLINK];
  logic [1:0] net_ff [NLINK];
  logic st_en_ff [NLINK];
  logic st_proc_ff [NLINK];
  logic [4:0] st_chan_ff [NLINK];
  logic [7:0] dst_link_ff [NLINK];
  logic [31:0] dirs_ff;
  logic [7:0] node_ff;
  logic [31:0] rdata_ff;
  logic [31:0] nxt_rdata;
  logic [NLINK-1:0] src_busy;
  logic [NLINK-1:0] junk;
  logic [NLINK-1:0] accept;
  logic [3:0] route_dir [NLINK];
  logic [31:0] link_word [NLINK];
  logic [31:0] static_word [NLINK];

  logic link_hit;
  logic static_hit;
  logic [2:0] link_idx;
  logic [2:0] static_link;

  assign link_hit = (i_addr >= lsf_pkg::REG_LINK_BASE) && (i_addr < lsf_pkg::REG_LINK_LAST);
  assign link_idx = i_addr[2:0];
  assign static_hit = (i_addr >= lsf_pkg::REG_STATIC_BASE) && (i_addr <= lsf_pkg::REG_STATIC_LAST);
  assign static_link = lsf_pkg::STATIC_LINK_MAP[i_addr[2:0]*3 +: 3];

  // ------------------------------------------------------------
  // per-link tracking, routing and word assembly
  // ------------------------------------------------------------
  for (genvar l = 0; l < NLINK; l++) begin : g_link
    lsf_route_if rif ();

    assign rif.node_id = node_ff;
    assign rif.pkt_node = i_hdr_node[l*8 +: 8];
    assign rif.dirs = dirs_ff;
    assign route_dir[l] = rif.mismatch ? rif.dir : dir_ff[l];

    lsf_route u_route (
      .rif(rif.rt)
    );

    lsf_link_track u_track (
      .i_ref_clk(i_ref_clk),
      .i_rst(i_rst),
      .i_hdr_valid(i_hdr_valid[l]),
      .i_hdr_junk(i_hdr_junk[l]),
      .i_pkt_end(i_pkt_end[l]),
      .o_src_busy(src_busy[l]),
      .o_junk(junk[l]),
      .o_accept(accept[l])
    );

    always_comb begin
      link_word[l] = 32'h0000_0000;
      link_word[l][lsf_pkg::SRC_TYPE_LSB +: 2] = i_src_type[l*2 +: 2];
      link_word[l][lsf_pkg::DST_LINK_LSB +: 8] = src_busy[l] ? dst_link_ff[l] : 8'h00;
      link_word[l][lsf_pkg::DIR_LSB +: 4] = dir_ff[l];
      link_word[l][lsf_pkg::NET_LSB +: 2] = net_ff[l];
      link_word[l][lsf_pkg::JUNK_BIT] = junk[l];
      link_word[l][lsf_pkg::DST_BUSY_BIT] = i_dst_busy[l];
      link_word[l][lsf_pkg::SRC_BUSY_BIT] = src_busy[l];
    end

    always_comb begin
      static_word[l] = 32'h0000_0000;
      static_word[l][lsf_pkg::STATIC_EN_BIT] = st_en_ff[l];
      static_word[l][lsf_pkg::STATIC_PROC_BIT] = st_proc_ff[l];
      static_word[l][lsf_pkg::STATIC_CHAN_LSB +: 5] = st_chan_ff[l];
    end

    // destination link captured with the header
    always_ff @(posedge i_ref_clk or posedge i_rst) begin
      if (i_rst) begin
        dst_link_ff[l] <= 8'h00;
      end else if (accept[l]) begin
        dst_link_ff[l] <= i_hdr_dst_link[l*8 +: 8];
      end
    end

    // forwarding decision, one pulse per header accepted while the link is idle
    always_ff @(posedge i_ref_clk or posedge i_rst) begin
      if (i_rst) begin
        o_fwd_valid[l] <= 1'b0;
        o_fwd_drop[l] <= 1'b0;
        o_fwd_static[l] <= 1'b0;
        o_fwd_proc[l] <= 1'b0;
        o_fwd_chanend[l*5 +: 5] <= 5'h00;
        o_fwd_dir[l*4 +: 4] <= 4'h0;
        o_fwd_net[l*2 +: 2] <= 2'h0;
      end else begin
        o_fwd_valid[l] <= accept[l] && !i_hdr_junk[l];
        o_fwd_drop[l] <= accept[l] && i_hdr_junk[l];
        if (accept[l]) begin
          o_fwd_static[l] <= st_en_ff[l];
          o_fwd_proc[l] <= st_en_ff[l] && st_proc_ff[l];
          o_fwd_chanend[l*5 +: 5] <= st_en_ff[l] ? st_chan_ff[l] : 5'h00;
          o_fwd_dir[l*4 +: 4] <= st_en_ff[l] ? 4'h0 : route_dir[l];
          o_fwd_net[l*2 +: 2] <= net_ff[l];
        end
      end
    end

    // ------------------------------------------------------------
    // per-link checks
    // ------------------------------------------------------------
    a_static_chan: assert property (@(posedge i_ref_clk) disable iff (i_rst)
      accept[l] && !i_hdr_junk[l] && st_en_ff[l] && !(i_wr && static_hit && static_link == l)
      |=> o_fwd_valid[l] && o_fwd_static[l] && o_fwd_chanend[l*5 +: 5] == $past(st_chan_ff[l])
      && o_fwd_proc[l] == $past(st_proc_ff[l]) && o_fwd_dir[l*4 +: 4] == 4'h0)
      else $error("static forward mismatch");
    a_junk_dropped: assert property (@(posedge i_ref_clk) disable iff (i_rst)
      accept[l] && i_hdr_junk[l] |=> !o_fwd_valid[l] && o_fwd_drop[l] ##1 junk[l] || $past(i_pkt_end[l]))
      else $error("junk packet forwarded");
    a_routed_dir: assert property (@(posedge i_ref_clk) disable iff (i_rst)
      accept[l] && !st_en_ff[l] && (i_hdr_node[l*8 +: 8] ^ node_ff) == 8'h80 && !i_wr
      |=> o_fwd_dir[l*4 +: 4] == $past(dirs_ff[31:28]))
      else $error("routed direction wrong");
    a_routed_fields: assert property (@(posedge i_ref_clk) disable iff (i_rst)
      accept[l] && !st_en_ff[l] |=> !o_fwd_static[l] && !o_fwd_proc[l] && o_fwd_chanend[l*5 +: 5] == 5'h00)
      else $error("routed packet carries static fields");
    a_src_busy_set: assert property (@(posedge i_ref_clk) disable iff (i_rst)
      accept[l] |=> src_busy[l])
      else $error("source side not busy after header");
    a_busy_clears: assert property (@(posedge i_ref_clk) disable iff (i_rst)
      src_busy[l] && i_pkt_end[l] |=> !src_busy[l])
      else $error("source side busy after packet end");
    a_dst_captured: assert property (@(posedge i_ref_clk) disable iff (i_rst)
      accept[l] |=> link_word[l][lsf_pkg::DST_LINK_LSB +: 8] == $past(i_hdr_dst_link[l*8 +: 8]))
      else $error("destination link not shown");
    a_net_at_accept: assert property (@(posedge i_ref_clk) disable iff (i_rst)
      accept[l] |=> o_fwd_net[l*2 +: 2] == $past(net_ff[l]))
      else $error("network number not forwarded");
    a_route_fallback: assert property (@(posedge i_ref_clk) disable iff (i_rst)
      accept[l] && !st_en_ff[l] && i_hdr_node[l*8 +: 8] == node_ff
      |=> o_fwd_dir[l*4 +: 4] == $past(dir_ff[l]))
      else $error("own direction not used");
    a_junk_shown: assert property (@(posedge i_ref_clk) disable iff (i_rst)
      accept[l] && i_hdr_junk[l] |=> junk[l])
      else $error("junk flag not set");
  end

  // ------------------------------------------------------------
  // register writes
  // ------------------------------------------------------------
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      for (int l = 0; l < NLINK; l++) begin
        dir_ff[l] <= lsf_pkg::DIR_RST;
        net_ff[l] <= lsf_pkg::NET_RST;
      end
    end else if (i_wr && link_hit) begin
      dir_ff[link_idx] <= i_wdata[lsf_pkg::DIR_LSB +: 4];
      net_ff[link_idx] <= i_wdata[lsf_pkg::NET_LSB +: 2];
    end
  end

  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      for (int l = 0; l < NLINK; l++) begin
        st_en_ff[l] <= 1'b0;
        st_proc_ff[l] <= 1'b0;
        st_chan_ff[l] <= lsf_pkg::CHAN_RST;
      end
    end else if (i_wr && static_hit) begin
      st_en_ff[static_link] <= i_wdata[lsf_pkg::STATIC_EN_BIT];
      st_proc_ff[static_link] <= i_wdata[lsf_pkg::STATIC_PROC_BIT];
      st_chan_ff[static_link] <= i_wdata[lsf_pkg::STATIC_CHAN_LSB +: 5];
    end
  end

  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      dirs_ff <= lsf_pkg::DIRS_RST;
      node_ff <= lsf_pkg::NODE_RST;
    end else if (i_wr) begin
      if (i_addr == lsf_pkg::REG_DIRS) begin
        dirs_ff <= i_wdata;
      end
      if (i_addr == lsf_pkg::REG_NODE_ID) begin
        node_ff <= i_wdata[7:0];
      end
    end
  end

  // ------------------------------------------------------------
  // register reads, data one cycle after the strobe
  // ------------------------------------------------------------
  always_comb begin
    nxt_rdata = 32'h0000_0000;
    if (i_rd) begin
      if (link_hit) begin
        nxt_rdata = link_word[link_idx];
      end else if (static_hit) begin
        nxt_rdata = static_word[static_link];
      end else if (i_addr == lsf_pkg::REG_DIRS) begin
        nxt_rdata = dirs_ff;
      end else if (i_addr == lsf_pkg::REG_NODE_ID) begin
        nxt_rdata = {24'h00_0000, node_ff};
      end
    end
  end

  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      rdata_ff <= 32'h0000_0000;
    end else begin
      rdata_ff <= nxt_rdata;
    end
  end

  assign o_rdata = rdata_ff;

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  a_link_rsvd: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    i_rd && link_hit |=> (o_rdata & lsf_pkg::LINK_RSVD_MASK) == 32'h0000_0000)
    else $error("link word reserved bits set");
  a_static_rsvd: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    i_rd && static_hit |=> (o_rdata & lsf_pkg::STATIC_RSVD_MASK) == 32'h0000_0000)
    else $error("static word reserved bits set");
  a_dir_write: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    i_wr && link_hit ##1 i_rd && i_addr == $past(i_addr)
    |=> o_rdata[11:4] == {$past(i_wdata[11:8], 2), 2'b00, $past(i_wdata[5:4], 2)})
    else $error("direction or network not stored");
  a_static_write: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    i_wr && static_hit ##1 i_rd && i_addr == $past(i_addr)
    |=> o_rdata == ($past(i_wdata, 2) & ~lsf_pkg::STATIC_RSVD_MASK))
    else $error("static word not stored");
  a_status_bits: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    i_rd && link_hit |=> o_rdata[1:0] == {$past(i_dst_busy[link_idx]), $past(src_busy[link_idx])}
    && o_rdata[25:24] == $past(i_src_type[link_idx*2 +: 2]))
    else $error("status bits wrong");
  a_dst_idle_zero: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    i_rd && link_hit && !src_busy[link_idx] |=> o_rdata[23:16] == 8'h00)
    else $error("destination shown while idle");
  a_ninth_zero: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    i_rd && i_addr == lsf_pkg::REG_LINK_LAST |=> o_rdata == 32'h0000_0000)
    else $error("register past link seven not zero");

  // ------------------------------------------------------------
  // read port timing and own registers
  // ------------------------------------------------------------
  a_rdata_idle: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    !i_rd |=> o_rdata == 32'h0000_0000)
    else $error("read data outside read cycle");
  a_dirs_write: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    i_wr && i_addr == lsf_pkg::REG_DIRS |=> dirs_ff == $past(i_wdata))
    else $error("dimension table not stored");
  a_dirs_readback: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    i_rd && i_addr == lsf_pkg::REG_DIRS |=> o_rdata == $past(dirs_ff))
    else $error("dimension table read wrong");
  a_node_readback: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    i_rd && i_addr == lsf_pkg::REG_NODE_ID |=> o_rdata == {24'h00_0000, $past(node_ff)})
    else $error("node id read wrong");
endmodule

// ---- hw/lsf_pkg.sv ----
// package: register map, field layout and reset values of the link status
// and static forwarding block
// assumes: register numbers are word indices on a plain register port
package lsf_pkg;
  localparam int NLINK = 8;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int NODE_W = 8;

  // ------------------------------------------------------------
  // register numbers
  // ------------------------------------------------------------
  localparam logic [7:0] REG_DIRS = 8'h0c;
  localparam logic [7:0] REG_NODE_ID = 8'h30;
  localparam logic [7:0] REG_LINK_BASE = 8'h20;
  localparam logic [7:0] REG_LINK_LAST = 8'h28;
  localparam logic [7:0] REG_STATIC_BASE = 8'ha0;
  localparam logic [7:0] REG_STATIC_LAST = 8'ha7;

  // ------------------------------------------------------------
  // link status word fields
  // ------------------------------------------------------------
  localparam int SRC_TYPE_LSB = 24;
  localparam int DST_LINK_LSB = 16;
  localparam int DIR_LSB = 8;
  localparam int NET_LSB = 4;
  localparam int JUNK_BIT = 2;
  localparam int DST_BUSY_BIT = 1;
  localparam int SRC_BUSY_BIT = 0;
  localparam logic [31:0] LINK_RSVD_MASK = 32'hfc00_f0c8;

  // ------------------------------------------------------------
  // static configuration word fields
  // ------------------------------------------------------------
  localparam int STATIC_EN_BIT = 31;
  localparam int STATIC_PROC_BIT = 8;
  localparam int STATIC_CHAN_LSB = 0;
  localparam logic [31:0] STATIC_RSVD_MASK = 32'h7fff_fee0;

  // ------------------------------------------------------------
  // reset values
  // ------------------------------------------------------------
  localparam logic [3:0] DIR_RST = 4'h0;
  localparam logic [1:0] NET_RST = 2'h0;
  localparam logic [4:0] CHAN_RST = 5'h00;
  localparam logic [31:0] DIRS_RST = 32'h0000_0000;
  localparam logic [7:0] NODE_RST = 8'h00;

  // static word k serves link C, D, A, B, G, H, E, F (links A..H = 0..7)
  localparam logic [23:0] STATIC_LINK_MAP = {3'h5, 3'h4, 3'h7, 3'h6, 3'h1, 3'h0, 3'h3, 3'h2};

  typedef enum logic [1:0] {
    SRC_SERIAL_LINK = 2'b00,
    SRC_PROCESSOR_LINK = 2'b01,
    SRC_SWITCH_CONTROL_TARGET = 2'b10,
    SRC_UNDEFINED = 2'b11
  } lsf_source_target_type_t;

  typedef enum logic [1:0] {
    LINK_IDLE = 2'b00,
    LINK_ACTIVE = 2'b01,
    LINK_JUNK = 2'b10
  } lsf_link_state_t;
endpackage

// ---- hw/lsf_route_if.sv ----
// interface: node identifiers and dimension table in, chosen direction out
// assumes: the router side is purely combinational
interface lsf_route_if;
  logic [7:0] node_id;
  logic [7:0] pkt_node;
  logic [31:0] dirs;
  logic [3:0] dir;
  logic mismatch;
  modport top (output node_id, output pkt_node, output dirs, input dir, input mismatch);
  modport rt (input node_id, input pkt_node, input dirs, output dir, output mismatch);
endinterface

// ---- hw/lsf_route.sv ----
// routing decode: direction from the highest differing node id bit
// assumes: table holds one 4-bit direction per dimension
module lsf_route (
  lsf_route_if.rt rif
);
  logic [7:0] diff;
  logic [3:0] dir;

  assign diff = rif.node_id ^ rif.pkt_node;

  // ------------------------------------------------------------
  // most significant mismatch picks the dimension
  // ------------------------------------------------------------
  always_comb begin
    dir = 4'h0;
    for (int d = 0; d < 8; d++) begin
      if (diff[d]) begin
        dir = rif.dirs[d*4 +: 4];
      end
    end
  end

  assign rif.dir = dir;
  assign rif.mismatch = |diff;
endmodule

// ---- hw/lsf_link_track.sv ----
// per-link packet tracker: source busy and junk state
// assumes: a header and its packet end never coincide
module lsf_link_track (
  input wire logic i_ref_clk,
  input wire logic i_rst,
  input wire logic i_hdr_valid,
  input wire logic i_hdr_junk,
  input wire logic i_pkt_end,
  output logic o_src_busy,
  output logic o_junk,
  output logic o_accept
);
  lsf_pkg::lsf_link_state_t state_ff;
  lsf_pkg::lsf_link_state_t nxt_state;

  assign o_accept = (state_ff == lsf_pkg::LINK_IDLE) && i_hdr_valid;

  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      lsf_pkg::LINK_IDLE: begin
        if (i_hdr_valid) begin
          nxt_state = i_hdr_junk ? lsf_pkg::LINK_JUNK : lsf_pkg::LINK_ACTIVE;
        end
      end
      lsf_pkg::LINK_ACTIVE,
      lsf_pkg::LINK_JUNK: begin
        if (i_pkt_end) begin
          nxt_state = lsf_pkg::LINK_IDLE;
        end
      end
      default: nxt_state = lsf_pkg::LINK_IDLE;
    endcase
  end

  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      state_ff <= lsf_pkg::LINK_IDLE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  assign o_src_busy = (state_ff != lsf_pkg::LINK_IDLE);
  assign o_junk = (state_ff == lsf_pkg::LINK_JUNK);

  a_junk_holds: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    o_junk && !i_pkt_end |=> o_junk) else $error("junk flag dropped early");
endmodule

// ---- sim/tb.sv ----
// testbench: link status, direction, network and static forwarding registers
// assumes: lsf_top compiled with lsf_pkg; bench drives every port itself
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  // ------------------------------------------------------------
  // clock, reset and ports
  // ------------------------------------------------------------
  logic i_ref_clk = 1'b0;
  logic i_rst = 1'b1;
  logic [7:0] i_addr = 8'h00;
  logic [31:0] i_wdata = 32'h0000_0000;
  logic i_wr = 1'b0;
  logic i_rd = 1'b0;
  logic [31:0] o_rdata;
  logic [7:0] i_hdr_valid = 8'h00;
  logic [7:0] i_hdr_junk = 8'h00;
  logic [63:0] i_hdr_node = 64'h0;
  logic [63:0] i_hdr_dst_link = 64'h0;
  logic [7:0] i_pkt_end = 8'h00;
  logic [7:0] i_dst_busy = 8'h00;
  logic [15:0] i_src_type = 16'h0000;
  logic [7:0] o_fwd_valid, o_fwd_drop, o_fwd_static, o_fwd_proc;
  logic [39:0] o_fwd_chanend;
  logic [31:0] o_fwd_dir;
  logic [15:0] o_fwd_net;
  int err_total = 0;
  int check_count = 0;
  int cycles = 0;
  logic [31:0] d;

  always #4 i_ref_clk = ~i_ref_clk;

  lsf_top lsf_top_i (.i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_hdr_valid(i_hdr_valid), .i_hdr_junk(i_hdr_junk),
    .i_hdr_node(i_hdr_node), .i_hdr_dst_link(i_hdr_dst_link), .i_pkt_end(i_pkt_end),
    .i_dst_busy(i_dst_busy), .i_src_type(i_src_type), .o_fwd_valid(o_fwd_valid),
    .o_fwd_drop(o_fwd_drop), .o_fwd_static(o_fwd_static), .o_fwd_proc(o_fwd_proc),
    .o_fwd_chanend(o_fwd_chanend), .o_fwd_dir(o_fwd_dir), .o_fwd_net(o_fwd_net));

  // ------------------------------------------------------------
  // shared tasks
  // ------------------------------------------------------------
  task automatic stop_test();
    $display("mismatches %0d, comparisons %0d", err_total, check_count);
    if (err_total == 0 && check_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [31:0] v);
    @(posedge i_ref_clk);
    i_addr <= a;
    i_wdata <= v;
    i_wr <= 1'b1;
    @(posedge i_ref_clk);
    i_wr <= 1'b0;
  endtask

  task automatic rd_reg(input logic [7:0] a, output logic [31:0] v);
    @(posedge i_ref_clk);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_ref_clk);
    i_rd <= 1'b0;
    #1;
    v = o_rdata;
  endtask

  task automatic wr_rd_reg(input logic [7:0] a, input logic [31:0] v, output logic [31:0] r);
    @(posedge i_ref_clk);
    i_addr <= a;
    i_wdata <= v;
    i_wr <= 1'b1;
    @(posedge i_ref_clk);
    i_wr <= 1'b0;
    i_rd <= 1'b1;
    @(posedge i_ref_clk);
    i_rd <= 1'b0;
    #1;
    r = o_rdata;
  endtask

  task automatic send_hdr(input int l, input logic junk, input logic [7:0] node, input logic [7:0] dl);
    @(posedge i_ref_clk);
    i_hdr_valid[l] <= 1'b1;
    i_hdr_junk[l] <= junk;
    i_hdr_node[l*8+:8] <= node;
    i_hdr_dst_link[l*8+:8] <= dl;
    @(posedge i_ref_clk);
    i_hdr_valid[l] <= 1'b0;
    i_hdr_junk[l] <= 1'b0;
    #1;
  endtask

  task automatic end_pkt(input int l);
    @(posedge i_ref_clk);
    i_pkt_end[l] <= 1'b1;
    @(posedge i_ref_clk);
    i_pkt_end[l] <= 1'b0;
  endtask

  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic t_reset();
    for (int k = 0; k < 8; k++) begin
      rd_reg(8'h20 + 8'(k), d);
      chk(d, 32'h0000_0000);
      rd_reg(8'ha0 + 8'(k), d);
      chk(d, 32'h0000_0000);
    end
  endtask

  task automatic t_rw();
    for (int k = 0; k < 8; k++) begin
      wr_rd_reg(8'h20 + 8'(k), 32'hffff_f0ff | (32'(k) << 8), d);
      chk(d, (32'(k) << 8) | 32'h30);
      wr_rd_reg(8'ha0 + 8'(k), 32'hffff_ffff, d);
      chk(d, 32'h8000_011f);
      @(posedge i_ref_clk);
      #1;
      chk(o_rdata, 32'h0000_0000);
      wr_reg(8'ha0 + 8'(k), 32'h0000_0000);
    end
    wr_rd_reg(8'h28, 32'hffff_ffff, d);
    chk(d, 32'h0000_0000);
  endtask

  task automatic t_src_type();
    @(posedge i_ref_clk);
    i_src_type <= 16'he4e4;
    for (int k = 0; k < 8; k++) begin
      rd_reg(8'h20 + 8'(k), d);
      chk(d, (32'(k % 4) << 24) | (32'(k) << 8) | 32'h30);
    end
    @(posedge i_ref_clk);
    i_src_type <= 16'h0000;
  endtask

  task automatic t_busy();
    i_dst_busy <= 8'h02;
    send_hdr(1, 1'b0, 8'h00, 8'h5a);
    chk(32'(o_fwd_valid), 32'h02);
    chk(32'(o_fwd_drop), 32'h00);
    chk(32'(o_fwd_dir[7:4]), 32'h1);
    chk(32'(o_fwd_net[3:2]), 32'h3);
    rd_reg(8'h21, d);
    chk(d, 32'h005a_0133);
    send_hdr(1, 1'b0, 8'h00, 8'h11);
    chk(32'(o_fwd_valid), 32'h00);
    rd_reg(8'h21, d);
    chk(d, 32'h005a_0133);
    end_pkt(1);
    i_dst_busy <= 8'h00;
    rd_reg(8'h21, d);
    chk(d, 32'h0000_0130);
  endtask

  task automatic t_junk();
    send_hdr(3, 1'b1, 8'h00, 8'h22);
    chk(32'(o_fwd_drop), 32'h08);
    chk(32'(o_fwd_valid), 32'h00);
    rd_reg(8'h23, d);
    chk(d, 32'h0022_0335);
    end_pkt(3);
    rd_reg(8'h23, d);
    chk(d, 32'h0000_0330);
  endtask

  task automatic t_route();
    wr_reg(8'h30, 32'h0000_000f);
    wr_reg(8'h0c, 32'h8765_4321);
    rd_reg(8'h30, d);
    chk(d, 32'h0000_000f);
    rd_reg(8'h0c, d);
    chk(d, 32'h8765_4321);
    for (int b = 0; b < 8; b++) begin
      send_hdr(0, 1'b0, 8'h0f ^ (8'h01 << b), 8'h01);
      chk(32'(o_fwd_dir[3:0]), 32'(b + 1));
      chk(32'(o_fwd_static[0]), 32'h0);
      end_pkt(0);
    end
  endtask

  task automatic t_static();
    int lmap[8] = '{2, 3, 0, 1, 6, 7, 4, 5};
    int l;
    for (int k = 0; k < 8; k++) begin
      l = lmap[k];
      wr_reg(8'ha0 + 8'(k), 32'h8000_0000 | (32'(k & 1) << 8) | 32'(k + 16));
      send_hdr(l, 1'b0, 8'h55, 8'h03);
      chk(32'(o_fwd_valid[l]), 32'h1);
      chk(32'(o_fwd_static[l]), 32'h1);
      chk(32'(o_fwd_proc[l]), 32'(k & 1));
      chk(32'(o_fwd_chanend[l*5+:5]), 32'(k + 16));
      chk(32'(o_fwd_dir[l*4+:4]), 32'h0);
      end_pkt(l);
      wr_reg(8'ha0 + 8'(k), 32'h0000_0000);
    end
  endtask

  task automatic t_mid_reset();
    wr_reg(8'ha0, 32'h8000_011f);
    @(posedge i_ref_clk);
    i_rst <= 1'b1;
    repeat (2) @(posedge i_ref_clk);
    chk(32'(o_fwd_static), 32'h00);
    chk(32'(|o_fwd_chanend), 32'h0);
    i_rst <= 1'b0;
    t_reset();
    rd_reg(8'h0c, d);
    chk(d, 32'h0000_0000);
    rd_reg(8'h30, d);
    chk(d, 32'h0000_0000);
  endtask

  // ------------------------------------------------------------
  // main sequence and timeout
  // ------------------------------------------------------------
  always @(posedge i_ref_clk) begin
    cycles++;
    if (cycles == 5000) begin
      err_total++;
      stop_test();
    end
  end

  initial begin
    repeat (5) @(posedge i_ref_clk);
    i_rst <= 1'b0;
    t_reset();
    t_rw();
    t_src_type();
    t_busy();
    t_junk();
    t_route();
    t_static();
    t_mid_reset();
    stop_test();
  end
endmodule
